// *** hdl/shared_port_cfg.svh ***
// Offsets, field positions, reset values and timing counts for the shared port.
`ifndef SHARED_PORT_CFG_SVH
`define SHARED_PORT_CFG_SVH

`define CLK_MHZ 250
`define STROBE_NS 500
`define STROBE_CYC ((`STROBE_NS * `CLK_MHZ + 999) / 1000)
`define STEP_NS 4000
`define STEP_CYC ((`STEP_NS * `CLK_MHZ + 999) / 1000)

`define OFS_CONFIG 8'h00
`define OFS_PAR_DATA 8'h04
`define OFS_PAR_CTRL 8'h08
`define OFS_PAR_STATUS 8'h0C
`define OFS_FDC_CTRL 8'h10
`define OFS_FDC_STATUS 8'h14

`define CFG_FUNC 0
`define CFG_MODE_LO 1
`define CFG_DATA_IN 3
`define CFG_CTL_RELEASE 4
`define PCTL_LINE_FEED 0
`define PCTL_INIT 1
`define PCTL_SELECT_IN 2
`define PCTL_STROBE_GO 3
`define PCTL_PIN_LO 4
`define PST_ACK_SEEN 5
`define PST_REFUSED 6
`define FCTL_STEP_GO 7
`define FCTL_STEP_BUSY 8
`define FST_INDEX_SEEN 5

`define PIN_STROBE 0
`define PIN_LINE_FEED 1
`define PIN_INDEX 2
`define PIN_ERROR 3
`define PIN_TRACK0 4
`define PIN_INIT 5
`define PIN_WPROT 6
`define PIN_SELECT_IN 7
`define PIN_RDATA 8
`define PIN_MEDIA 10
`define PIN_ACK 18
`define PIN_BUSY 20
`define PIN_PAPER 22
`define PIN_SELECTED 24
`define PIN_COUNT 26

`define RST_PAR_DATA 8'h00
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// *** hdl/shared_port_pkg.sv ***
// Types shared by the printer and floppy port logic.
package shared_port_pkg;

  typedef enum logic {
    FUNC_FLOPPY,
    FUNC_PRINTER
  } func_t;

  typedef enum logic [1:0] {
    MODE_SPP,
    MODE_BIDIR,
    MODE_EPP,
    MODE_ECP
  } par_mode_t;

  typedef struct packed {
    logic ctl_release;
    logic data_in;
    par_mode_t mode;
    func_t func;
  } config_t;

  typedef struct packed {
    logic wr_bit;
    logic write_gate;
    logic motor_on;
    logic drive_select;
    logic outward;
    logic side;
    logic density_high;
  } fdc_ctrl_t;

endpackage

// *** hdl/low_pulse_timer.sv ***
// One-shot timer that stays busy for a programmed number of cycles.
`timescale 1ns/1ns
module low_pulse_timer (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Control.
  input wire logic start,
  input wire logic [15:0] width,
  // Status.
  output logic busy
);

  logic [15:0] count;

  // A start while busy is ignored so a pulse is never stretched.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= 16'h0000;
      busy <= 1'b0;
    end else if (start && !busy) begin
      count <= width;
      busy <= 1'b1;
    end else if (busy) begin
      count <= count - 16'h0001;
      busy <= (count != 16'h0001);
    end
  end

endmodule

// *** hdl/shared_printer_floppy_port.sv ***
// Shared printer and floppy connector logic with an AXI4-Lite register slave.
//
// Contract
// - Printer and floppy signals leave through one connector, pins multiplexed.
// - One function active at a time; floppy selected after reset.
// - Printer side offers standard, bidirectional, EPP and ECP modes.
// - Active-low strobe pulses data into printer; I/O pin in EPP/ECP.
// - Active-low initialize is output in standard mode, I/O in EPP/ECP.
// - Select-in is an output in standard mode, I/O in EPP/ECP.
// - Active-low auto-feed output asks printer for a line feed.
// - Eight data bits zero to seven on connector pins 3 to 17, five of them shared with floppy inputs.
// - Floppy density output shows low or high data rate chosen.
// - Side select output 0 picks side 1, 1 picks side 0.
// - Direction 0 inward, 1 outward; one low step pulse per move.
// - One low-going step pulse per single-track head movement.
// - Writes send encoded data and assert the write gate.
// - Drive-select and motor-enable outputs for floppy drive 1.
`timescale 1ns/1ns
`include "shared_port_cfg.svh"
module shared_printer_floppy_port (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // AXI4-Lite write channels.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Floppy bit streams to and from the controller core.
  input wire logic fdc_write_data,
  output logic fdc_read_data,
  // Connector pins, index is pin number minus one.
  input wire logic [25:0] conn_in,
  output logic [25:0] conn_out,
  output logic [25:0] conn_oe
);

  shared_port_pkg::config_t cfg;
  shared_port_pkg::fdc_ctrl_t fdc;
  logic [7:0] pending_data;
  logic [7:0] present_data;
  logic line_feed;
  logic init_req;
  logic select_in;
  logic ack_seen;
  logic refused;
  logic index_seen;
  logic [25:0] pin_q;
  logic [25:0] pin_prev;
  logic aw_full;
  logic w_full;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic strobe_busy;
  logic step_busy;
  logic strobe_start;
  logic step_start;
  logic [25:0] data_pin_out;
  logic [25:0] data_pin_oe;
  logic [25:0] next_out;
  logic [25:0] next_oe;

  logic aw_take;
  logic w_take;
  logic ar_take;
  logic next_aw_full;
  logic next_w_full;
  logic wr_fire;
  logic next_bvalid;
  logic next_rvalid;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_lo;
  logic printer;
  logic ctl_io;
  logic ack_fall;
  logic index_fall;
  logic [31:0] read_word;
  logic read_hit;

  assign printer = (cfg.func == shared_port_pkg::FUNC_PRINTER);
  // Control lines turn into I/O pins only in the enhanced modes.
  assign ctl_io = (cfg.mode == shared_port_pkg::MODE_EPP) ||
                  (cfg.mode == shared_port_pkg::MODE_ECP);

  // Bus handshake. Address and data may arrive in either order; the
  // response waits for both, and no new write is taken until it is accepted.
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign wr_fire = (aw_full || aw_take) && (w_full || w_take);
  assign next_aw_full = (aw_full || aw_take) && !wr_fire;
  assign next_w_full = (w_full || w_take) && !wr_fire;
  assign next_bvalid = wr_fire || (s_axi_bvalid && !s_axi_bready);
  assign next_rvalid = ar_take || (s_axi_rvalid && !s_axi_rready);
  assign wr_addr = aw_take ? s_axi_awaddr : aw_addr;
  assign wr_data = w_take ? s_axi_wdata : w_data;
  assign wr_strb = w_take ? s_axi_wstrb : w_strb;
  assign wr_lo = wr_fire && wr_strb[0];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      if (aw_take) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      s_axi_awready <= !next_aw_full && !next_bvalid;
      s_axi_wready <= !next_w_full && !next_bvalid;
      s_axi_bvalid <= next_bvalid;
      if (wr_fire) begin
        s_axi_bresp <= (wr_addr > `OFS_FDC_STATUS || wr_addr[1:0] != 2'b00) ?
                       `RESP_SLVERR : `RESP_OKAY;
      end
    end
  end

  // Read word assembly; error, index, track 0, protect and media pins read inverted, all other pin levels raw.
  always_comb begin
    read_word = 32'h0000_0000;
    read_hit = 1'b1;
    case (s_axi_araddr)
      `OFS_CONFIG: begin
        read_word[4:0] = cfg;
      end
      `OFS_PAR_DATA: begin
        for (int i = 0; i < 8; i++) begin
          read_word[i] = pin_q[2 + 2 * i];
        end
      end
      `OFS_PAR_CTRL: begin
        read_word[`PCTL_LINE_FEED] = line_feed;
        read_word[`PCTL_INIT] = init_req;
        read_word[`PCTL_SELECT_IN] = select_in;
        read_word[`PCTL_STROBE_GO] = strobe_busy;
        read_word[`PCTL_PIN_LO] = pin_q[`PIN_STROBE];
        read_word[`PCTL_PIN_LO + 1] = pin_q[`PIN_INIT];
        read_word[`PCTL_PIN_LO + 2] = pin_q[`PIN_SELECT_IN];
      end
      `OFS_PAR_STATUS: begin
        read_word[0] = !pin_q[`PIN_ERROR];
        read_word[1] = pin_q[`PIN_ACK];
        read_word[2] = pin_q[`PIN_BUSY];
        read_word[3] = pin_q[`PIN_PAPER];
        read_word[4] = pin_q[`PIN_SELECTED];
        read_word[`PST_ACK_SEEN] = ack_seen;
        read_word[`PST_REFUSED] = refused;
      end
      `OFS_FDC_CTRL: begin
        read_word[6:0] = fdc;
        read_word[`FCTL_STEP_BUSY] = step_busy;
      end
      `OFS_FDC_STATUS: begin
        read_word[0] = !pin_q[`PIN_INDEX];
        read_word[1] = !pin_q[`PIN_TRACK0];
        read_word[2] = !pin_q[`PIN_WPROT];
        read_word[3] = !pin_q[`PIN_MEDIA];
        read_word[4] = pin_q[`PIN_RDATA];
        read_word[`FST_INDEX_SEEN] = index_seen;
      end
      default: begin
        read_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (ar_take) begin
        s_axi_rdata <= read_word;
        s_axi_rresp <= read_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  // Configuration and control registers.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg <= '{ctl_release: 1'b0, data_in: 1'b0, mode: shared_port_pkg::MODE_SPP,
               func: shared_port_pkg::FUNC_FLOPPY};
      fdc <= '0;
      pending_data <= `RST_PAR_DATA;
      line_feed <= 1'b0;
      init_req <= 1'b0;
      select_in <= 1'b0;
    end else if (wr_lo) begin
      case (wr_addr)
        `OFS_CONFIG: begin
          cfg <= wr_data[4:0];
        end
        `OFS_PAR_DATA: begin
          pending_data <= wr_data[7:0];
        end
        `OFS_PAR_CTRL: begin
          line_feed <= wr_data[`PCTL_LINE_FEED];
          init_req <= wr_data[`PCTL_INIT];
          select_in <= wr_data[`PCTL_SELECT_IN];
        end
        `OFS_FDC_CTRL: begin
          fdc <= wr_data[6:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Pulse launches. A strobe while the printer is busy would hand it data it
  // cannot take, so it is dropped and flagged instead.
  assign strobe_start = wr_lo && wr_addr == `OFS_PAR_CTRL && wr_data[`PCTL_STROBE_GO] &&
                        printer && !pin_q[`PIN_BUSY] && !strobe_busy;
  assign step_start = wr_lo && wr_addr == `OFS_FDC_CTRL && wr_data[`FCTL_STEP_GO] &&
                      !printer;

  low_pulse_timer strobe_timer (
    .clk(clk),
    .arst_n(arst_n),
    .start(strobe_start),
    .width(16'(`STROBE_CYC)),
    .busy(strobe_busy)
  );

  low_pulse_timer step_timer (
    .clk(clk),
    .arst_n(arst_n),
    .start(step_start),
    .width(16'(`STEP_CYC)),
    .busy(step_busy)
  );

  // Data reaches the pins only while the printer is ready and no strobe runs.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      present_data <= `RST_PAR_DATA;
    end else if (!pin_q[`PIN_BUSY] && !strobe_busy) begin
      present_data <= pending_data;
    end
  end

  // Pin sampling and event flags; a new event in the clearing cycle wins.
  assign ack_fall = printer && pin_prev[`PIN_ACK] && !pin_q[`PIN_ACK];
  assign index_fall = !printer && pin_prev[`PIN_INDEX] && !pin_q[`PIN_INDEX];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_q <= '1;
      pin_prev <= '1;
      ack_seen <= 1'b0;
      refused <= 1'b0;
      index_seen <= 1'b0;
      fdc_read_data <= 1'b0;
    end else begin
      pin_q <= conn_in;
      pin_prev <= pin_q;
      fdc_read_data <= !printer && conn_in[`PIN_RDATA];
      if (ack_fall) begin
        ack_seen <= 1'b1;
      end else if (wr_lo && wr_addr == `OFS_PAR_STATUS && wr_data[`PST_ACK_SEEN]) begin
        ack_seen <= 1'b0;
      end
      if (wr_lo && wr_addr == `OFS_PAR_CTRL && wr_data[`PCTL_STROBE_GO] && !strobe_start) begin
        refused <= 1'b1;
      end else if (wr_lo && wr_addr == `OFS_PAR_STATUS && wr_data[`PST_REFUSED]) begin
        refused <= 1'b0;
      end
      if (index_fall) begin
        index_seen <= 1'b1;
      end else if (wr_lo && wr_addr == `OFS_FDC_STATUS && wr_data[`FST_INDEX_SEEN]) begin
        index_seen <= 1'b0;
      end
    end
  end

  // Data pins sit on every second connector pin from pin 3.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : data_pins
      assign data_pin_out[2 + 2 * gi] = present_data[gi];
      assign data_pin_oe[2 + 2 * gi] = printer &&
        (cfg.mode == shared_port_pkg::MODE_SPP || !cfg.data_in);
      assign data_pin_out[1 + 2 * gi] = 1'b0;
      assign data_pin_oe[1 + 2 * gi] = 1'b0;
    end
  endgenerate
  assign data_pin_out[25:17] = 9'h000;
  assign data_pin_oe[25:17] = 9'h000;
  assign data_pin_out[0] = 1'b0;
  assign data_pin_oe[0] = 1'b0;

  // Pin multiplexer. Pins of the idle function are released.
  always_comb begin
    next_out = 26'h000_0000;
    next_oe = 26'h000_0000;
    if (printer) begin
      next_out[`PIN_STROBE] = !strobe_busy;
      next_oe[`PIN_STROBE] = !(ctl_io && cfg.ctl_release);
      next_out[`PIN_LINE_FEED] = !line_feed;
      next_oe[`PIN_LINE_FEED] = 1'b1;
      next_out[`PIN_INIT] = !init_req;
      next_oe[`PIN_INIT] = !(ctl_io && cfg.ctl_release);
      next_out[`PIN_SELECT_IN] = !select_in;
      next_oe[`PIN_SELECT_IN] = !(ctl_io && cfg.ctl_release);
      next_out = next_out | data_pin_out;
      next_oe = next_oe | data_pin_oe;
    end else begin
      next_out[`PIN_LINE_FEED] = fdc.density_high;
      next_out[`PIN_ERROR] = !fdc.side;
      next_out[`PIN_INIT] = fdc.outward;
      next_out[`PIN_SELECT_IN] = !step_busy;
      next_out[`PIN_ACK] = !fdc.drive_select;
      next_out[`PIN_BUSY] = !fdc.motor_on;
      next_out[`PIN_PAPER] = fdc_write_data;
      // The gate is held off on a protected diskette so a bad command cannot erase it.
      next_out[`PIN_SELECTED] = !(fdc.write_gate && pin_q[`PIN_WPROT]);
      next_oe[`PIN_LINE_FEED] = 1'b1;
      next_oe[`PIN_ERROR] = 1'b1;
      next_oe[`PIN_INIT] = 1'b1;
      next_oe[`PIN_SELECT_IN] = 1'b1;
      next_oe[`PIN_ACK] = 1'b1;
      next_oe[`PIN_BUSY] = 1'b1;
      next_oe[`PIN_PAPER] = 1'b1;
      next_oe[`PIN_SELECTED] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      conn_out <= 26'h000_0000;
      conn_oe <= 26'h000_0000;
    end else begin
      conn_out <= next_out;
      conn_oe <= next_oe;
    end
  end

endmodule

// *** sim/port_partner.sv ***
// Behavioural printer or floppy drive on the far side of the shared connector.
`timescale 1ns/1ns
module port_partner (
  // Clock.
  input wire logic clk,
  // Attached device and the levels it reports.
  input wire logic printer,
  input wire logic [3:0] prn_st,
  input wire logic [3:0] fd_st,
  // Device side of the connector.
  input wire logic [25:0] conn_out,
  input wire logic [25:0] conn_oe,
  // Levels this side offers on every line.
  output logic [25:0] drv
);
  logic tog = 1'b0;
  logic stb_d = 1'b1;
  logic [2:0] ack_cnt = 3'h0;
  always_ff @(posedge clk) begin
    tog <= ~tog;
    stb_d <= conn_out[0] || !conn_oe[0];
    if (printer && conn_out[0] && conn_oe[0] && !stb_d) begin
      ack_cnt <= 3'h4;
    end else if (ack_cnt != 3'h0) begin
      ack_cnt <= ack_cnt - 3'h1;
    end
  end
  // Undriven lines alternate each cycle, so a stale level is never read back as data.
  always_comb begin
    drv = {13{tog, ~tog}};
    if (printer) begin
      drv[3] = prn_st[0];
      drv[18] = (ack_cnt == 3'h0);
      drv[20] = prn_st[1];
      drv[22] = prn_st[2];
      drv[24] = prn_st[3];
    end else begin
      drv[2] = fd_st[0];
      drv[4] = fd_st[1];
      drv[6] = fd_st[2];
      drv[8] = tog;
      drv[10] = fd_st[3];
    end
  end
endmodule

// *** sim/shared_printer_floppy_port_chk.sv ***
// Assertions on the shared printer and floppy port, bound to its top module.
`timescale 1ns/1ns
module port_chk (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Write channels.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  // Floppy streams and connector.
  input wire logic fdc_write_data,
  input wire logic fdc_read_data,
  input wire logic [25:0] conn_in,
  input wire logic [25:0] conn_out,
  input wire logic [25:0] conn_oe
);
  localparam int STROBE_LEN = 125;
  localparam int STEP_LEN = 1000;
  localparam logic [25:0] DATA_PINS = 26'h001_5554;
  // Configuration is mirrored from finished writes, lagging the register by the same edge
  // that the pins lag it, so the two stay in step.
  logic [7:0] aw_q;
  logic [4:0] wd_q;
  logic ws_q;
  logic b_d;
  logic [4:0] cfg_q;
  logic [1:0] rdy;
  logic [15:0] stb_lo;
  logic [15:0] stp_lo;
  always_ff @(posedge clk) begin
    if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata[4:0];
    if (s_axi_wvalid && s_axi_wready) ws_q <= s_axi_wstrb[0];
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      b_d <= 1'b0;
      cfg_q <= 5'h00;
      rdy <= 2'h0;
    end else begin
      b_d <= s_axi_bvalid;
      rdy <= {rdy[0], 1'b1};
      if (s_axi_bvalid && !b_d && aw_q == 8'h00 && ws_q) cfg_q <= wd_q;
    end
  end
  always_ff @(posedge clk) begin
    stb_lo <= (conn_out[0] || !conn_oe[0] || !cfg_q[0]) ? 16'h0000 : stb_lo + 16'h0001;
    stp_lo <= (conn_out[7] || !conn_oe[7] || cfg_q[0]) ? 16'h0000 : stp_lo + 16'h0001;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence busy_held;
    conn_in[20] [*3];
  endsequence
  chk_spare_undriven: assert property (rdy[1] |-> (conn_oe & 26'h2AA_AA00) == 26'h000_0000)
    else $error("spare pin driven");
  chk_floppy_drives: assert property (rdy[1] && !cfg_q[0] |-> conn_oe == 26'h154_00AA)
    else $error("floppy pin enables wrong");
  chk_spp_drives: assert property (rdy[1] && cfg_q[2:0] == 3'h1 |-> conn_oe == 26'h001_55F7)
    else $error("standard mode pin enables wrong");
  chk_ctl_release: assert property (rdy[1] && cfg_q[0] && cfg_q[2] && cfg_q[4]
    |-> !conn_oe[0] && !conn_oe[5] && !conn_oe[7] && conn_oe[1]) else $error("control not released");
  chk_data_release: assert property (rdy[1] && cfg_q[0] && cfg_q[2:1] != 2'h0 && cfg_q[3]
    |-> (conn_oe & DATA_PINS) == 26'h000_0000) else $error("data pins not released");
  chk_read_stream: assert property (rdy[1] && !cfg_q[0] |-> fdc_read_data == $past(conn_in[8]))
    else $error("read stream wrong");
  chk_write_stream: assert property (rdy[1] && !cfg_q[0] |-> conn_out[22] == $past(fdc_write_data))
    else $error("write stream wrong");
  chk_strobe_width: assert property (cfg_q[0] && $rose(conn_out[0]) && $past(conn_oe[0])
    |-> stb_lo == STROBE_LEN) else $error("strobe width wrong");
  chk_step_width: assert property (!cfg_q[0] && $rose(conn_out[7]) && $past(conn_oe[7])
    |-> stp_lo == STEP_LEN) else $error("step width wrong");
  chk_busy_hold: assert property (busy_held ##1 (rdy[1] && cfg_q[2:0] == 3'h1 && $stable(cfg_q))
    |-> $stable(conn_out & DATA_PINS)) else $error("data changed while busy");
  chk_write_resp: assert property ($rose(s_axi_bvalid)
    |-> s_axi_bresp == ((aw_q > 8'h14 || aw_q[1:0] != 2'h0) ? 2'h2 : 2'h0)) else $error("bad bresp");
endmodule
bind shared_printer_floppy_port port_chk port_chk_inst (.clk(clk), .arst_n(arst_n),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .fdc_write_data(fdc_write_data), .fdc_read_data(fdc_read_data), .conn_in(conn_in),
  .conn_out(conn_out), .conn_oe(conn_oe));

// *** sim/shared_printer_floppy_port_tb.sv ***
// Self-checking bench for the shared printer and floppy port.
`timescale 1ns/1ns
module shared_printer_floppy_port_tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic fwd = 1'b0;
  logic printer = 1'b0;
  logic [3:0] prn_st = 4'hC;
  logic [3:0] fd_st = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, frd;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [25:0] cin, cout, coe, drv;
  int fail_count = 0;
  int tests_run = 0;
  assign cin = (coe & cout) | (~coe & drv);
  shared_printer_floppy_port shared_printer_floppy_port_inst (.clk(clk), .arst_n(arst_n),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .fdc_write_data(fwd),
    .fdc_read_data(frd), .conn_in(cin), .conn_out(cout), .conn_oe(coe));
  port_partner port_partner_inst (.clk(clk), .printer(printer), .prn_st(prn_st),
    .fd_st(fd_st), .conn_out(cout), .conn_oe(coe), .drv(drv));
  initial forever #2 clk = ~clk;
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic lost;
    fail_count++;
    $display("[ERR] bus answer expected 1 seen 0");
    close_out();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 64 && !done; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        done = 1'b1;
        check("bresp", 32'(bresp), 32'(er));
      end
    end
    if (!done) lost();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q, input logic [1:0] er);
    logic done;
    done = 1'b0;
    q = 32'h0000_0000;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 64 && !done; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        q = rdata;
        done = 1'b1;
        check("rresp", 32'(rresp), 32'(er));
      end
    end
    if (!done) lost();
  endtask
  // Counts sampled low cycles of one pin; a pulse that never starts reads as zero.
  task automatic low_len(input int b, output int len);
    int n;
    n = 0;
    len = 0;
    while (cout[b] !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    while (cout[b] === 1'b0 && len < 2000) begin
      @(posedge clk);
      len++;
    end
  endtask
  function automatic logic [31:0] dpins(input logic [25:0] c);
    dpins = 32'h0000_0000;
    for (int i = 0; i < 8; i++) dpins[i] = c[2 + 2 * i];
  endfunction
  task automatic t_reset;
    logic [31:0] q;
    check("floppy oe", 32'(coe), 32'h0154_00AA);
    check("floppy idle", 32'(cout & 26'h154_00AA), 32'h0114_0088);
    rd(8'h00, q, 2'h0);
    check("config", q, 32'h0000_0000);
    rd(8'h40, q, 2'h2);
    wr(8'h41, 32'h0000_0001, 2'h2);
    $display("test reset done");
  endtask
  task automatic t_floppy;
    logic [31:0] q;
    int len;
    fwd <= 1'b1;
    wr(8'h10, 32'h0000_003F, 2'h0);
    repeat (3) @(posedge clk);
    check("floppy pins", 32'(cout & 26'h154_00AA), 32'h0040_00A2);
    fd_st <= 4'h0;
    repeat (4) @(posedge clk);
    check("gate protected", 32'(cout[24]), 32'h0000_0001);
    rd(8'h14, q, 2'h0);
    check("fdc status", q & 32'h0000_002F, 32'h0000_002F);
    wr(8'h14, 32'h0000_0020, 2'h0);
    rd(8'h14, q, 2'h0);
    check("index cleared", q & 32'h0000_0020, 32'h0000_0000);
    wr(8'h10, 32'h0000_00BF, 2'h0);
    low_len(7, len);
    check("step low", 32'(len), 32'd1000);
    check("dir held", 32'(cout[5]), 32'h0000_0001);
    fd_st <= 4'hF;
    $display("test floppy done");
  endtask
  task automatic t_printer;
    logic [31:0] q;
    int len;
    printer <= 1'b1;
    wr(8'h00, 32'h0000_0001, 2'h0);
    wr(8'h04, 32'h0000_00A5, 2'h0);
    repeat (4) @(posedge clk);
    check("spp oe", 32'(coe), 32'h0001_55F7);
    check("data pins", dpins(cout), 32'h0000_00A5);
    wr(8'h08, 32'h0000_0007, 2'h0);
    repeat (3) @(posedge clk);
    check("ctl pins", 32'({cout[7], cout[5], cout[1]}), 32'h0000_0000);
    wr(8'h08, 32'h0000_0008, 2'h0);
    low_len(0, len);
    check("strobe low", 32'(len), 32'd125);
    repeat (8) @(posedge clk);
    rd(8'h0C, q, 2'h0);
    check("status", q & 32'h0000_007F, 32'h0000_003B);
    prn_st <= 4'hE;
    repeat (4) @(posedge clk);
    wr(8'h04, 32'h0000_003C, 2'h0);
    wr(8'h08, 32'h0000_0008, 2'h0);
    repeat (10) @(posedge clk);
    check("held data", dpins(cout), 32'h0000_00A5);
    check("no strobe", 32'(cout[0]), 32'h0000_0001);
    rd(8'h0C, q, 2'h0);
    check("refused", (q >> 6) & 32'h0000_0001, 32'h0000_0001);
    wr(8'h0C, 32'h0000_0060, 2'h0);
    prn_st <= 4'hC;
    repeat (6) @(posedge clk);
    check("new data", dpins(cout), 32'h0000_003C);
    rd(8'h0C, q, 2'h0);
    check("flags cleared", (q >> 5) & 32'h0000_0003, 32'h0000_0000);
    $display("test printer done");
  endtask
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      wr(8'h00, 32'(32'h19 | (m << 1)), 2'h0);
      repeat (3) @(posedge clk);
      check("ctl oe", 32'({coe[7], coe[5], coe[0]}), (m >= 2) ? 32'h0 : 32'h7);
      check("data oe", 32'(coe[2]), (m == 0) ? 32'h1 : 32'h0);
    end
    printer <= 1'b0;
    wr(8'h00, 32'h0000_0000, 2'h0);
    repeat (3) @(posedge clk);
    check("back to floppy", 32'(coe), 32'h0154_00AA);
    $display("test modes done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_floppy();
    t_printer();
    t_modes();
    close_out();
  end
endmodule
